// *** rtl/frrc_fault_ctrl.sv ***
// Fault response, status, alert and retry control for one channel
//
// Overview of operation
// - Retry interval separates restarts, rounded down to whole 10 us steps.
// - One retry interval serves every fault that retries.
// - Retry timer starts at fault detection, not at shutdown end.
// - Retry wait is longer of interval and discharge, unless config bit 0.
// - Interval accepts 0.02 to 64000 ms, Linear11 or half float per bit 8.
// - Voltage faults act and drive fault pin only while channel is on.
// - Any detected fault pulls alert low unless masked, on or off.
// - Every response code sets status and alert.
// - Code 10 disables output at once, then follows retry setting.
// - Unsupported response codes are rejected with a CML fault.
// - Retry 000 to 110 keeps output off until channel commanded off.
// - Retry 111 restarts forever until off or a no-retry fault.
// - Code 01 runs for the delay, then applies retry if fault remains.
// - Delay field counts 10 us steps for output voltage faults.
// - Nonzero delay in input overvoltage action raises CML fault.
// - Output overvoltage code 00 keeps continuous mode regulation.
// - Undervoltage code 00 only records status and alerts.
// - Input overvoltage sets none-of-above, input word bit, input OV bit.
// - Output overvoltage sets VOUT_OV byte, VOUT word, OV fault and warn.
// - Undervoltage sets none-of-above, VOUT word, UV fault and warn.
// - Undervoltage stays masked until startup completes and threshold met while not in current limit.
// - Undervoltage masked while inactive and during ramps.
// - Startup timeout sets none-of-above, VOUT word, timeout bit.
// - Startup timeout action value 0 disables that response.
// - Config bit 0 drops the discharge requirement.
`timescale 1ns/10ps
`default_nettype none
module frrc_fault_ctrl (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic [15:0] cmd_rdata_o,
  output logic cml_fault_o,
  input wire logic clear_faults_i,
  input wire logic [4:0] alert_mask_i,
  input wire logic half_float_i,
  input wire logic discharge_skip_i,
  input wire logic channel_on_i,
  input wire logic turn_on_delay_done_i,
  input wire logic turn_on_ramp_done_i,
  input wire logic ramp_active_i,
  input wire logic uv_threshold_reached_i,
  input wire logic overcurrent_limit_i,
  input wire logic output_discharged_i,
  input wire logic vin_ov_i,
  input wire logic vout_ov_i,
  input wire logic vout_uv_i,
  input wire logic startup_timeout_i,
  output logic output_enable_o,
  output logic continuous_mode_o,
  output logic restart_o,
  output logic fault_b_o,
  output logic alert_b_o,
  output logic [7:0] status_byte_o,
  output logic [7:0] status_word_hi_o,
  output logic [7:0] status_input_o,
  output logic [7:0] status_vout_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] act_slot(input logic [7:0] code);
    unique case (code)
      frrc_pkg::CMD_VIN_OV: act_slot = {1'b1, frrc_pkg::F_VIN_OV};
      frrc_pkg::CMD_VOUT_OV: act_slot = {1'b1, frrc_pkg::F_VOUT_OV};
      frrc_pkg::CMD_VOUT_UV: act_slot = {1'b1, frrc_pkg::F_VOUT_UV};
      frrc_pkg::CMD_TON_MAX: act_slot = {1'b1, frrc_pkg::F_TON_MAX};
      default: act_slot = 3'h0;
    endcase
  endfunction

  function automatic logic act_valid(input logic [1:0] slot, input logic [7:0] d);
    logic [1:0] code;
    logic nodelay;
    code = d[frrc_pkg::CODE_HI:frrc_pkg::CODE_LO];
    nodelay = (slot == frrc_pkg::F_VIN_OV) || (slot == frrc_pkg::F_TON_MAX);
    act_valid = (code != frrc_pkg::CODE_BAD) &&
      !(slot == frrc_pkg::F_VIN_OV && code != frrc_pkg::CODE_SHUT) &&
      !(slot == frrc_pkg::F_TON_MAX && code == frrc_pkg::CODE_DELAY) &&
      !(nodelay && d[frrc_pkg::DELAY_HI:frrc_pkg::DELAY_LO] != 3'h0);
  endfunction

  // Steps of 10 us, rounded down; out of range saturates for rejection
  function automatic logic [23:0] interval_steps(input logic [15:0] raw,
                                                 input logic use_half);
    logic [10:0] man;
    logic [6:0] sh;
    logic [6:0] amt;
    logic [31:0] prod;
    logic [31:0] wide;
    if (!use_half) begin
      man = raw[10] ? 11'h000 : raw[10:0];
      sh = {{2{raw[15]}}, raw[15:11]};
    end else begin
      man = raw[15] ? 11'h000 : {(raw[14:10] != 5'h00), raw[9:0]};
      sh = (raw[14:10] == 5'h00) ? 7'h68 : ({2'h0, raw[14:10]} - 7'h19);
    end
    prod = {21'h00000, man} * frrc_pkg::MS_TO_STEPS;
    amt = sh[6] ? (~sh + 7'h01) : sh;
    if (!sh[6]) begin
      wide = (amt > 7'h0C) ? 32'hFFFFFFFF : (prod << amt);
    end else begin
      wide = (amt > 7'h1F) ? 32'h00000000 : (prod >> amt);
    end
    interval_steps = (wide > 32'h00FFFFFF) ? 24'hFFFFFF : wide[23:0];
  endfunction

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  logic [7:0] act [frrc_pkg::NFAULT];
  logic [15:0] retry_raw;
  logic [23:0] retry_steps;
  logic [2:0] wr_slot;
  logic [23:0] wr_steps;
  logic wr_act_ok;
  logic wr_retry_ok;
  logic cml_evt;

  assign wr_slot = act_slot(cmd_code_i);
  assign wr_steps = interval_steps(cmd_wdata_i, half_float_i);
  assign wr_act_ok = act_valid(wr_slot[1:0], cmd_wdata_i[7:0]);
  assign wr_retry_ok = (wr_steps >= frrc_pkg::MIN_STEPS) &&
    (wr_steps <= frrc_pkg::MAX_STEPS);
  assign cml_evt = cmd_wr_i && ((wr_slot[2] && !wr_act_ok) ||
    (cmd_code_i == frrc_pkg::CMD_RETRY && !wr_retry_ok));

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      act[frrc_pkg::F_VIN_OV] <= frrc_pkg::RST_VIN_OV;
      act[frrc_pkg::F_VOUT_OV] <= frrc_pkg::RST_VOUT_OV;
      act[frrc_pkg::F_VOUT_UV] <= frrc_pkg::RST_VOUT_UV;
      act[frrc_pkg::F_TON_MAX] <= frrc_pkg::RST_TON_MAX;
    end else if (cmd_wr_i && wr_slot[2] && wr_act_ok) begin
      act[wr_slot[1:0]] <= cmd_wdata_i[7:0];
    end
  end

  // Interval is converted once at write time so the timer compares steps
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      retry_raw <= frrc_pkg::RST_RETRY;
      retry_steps <= frrc_pkg::RST_RETRY_STEPS;
    end else if (cmd_wr_i && cmd_code_i == frrc_pkg::CMD_RETRY && wr_retry_ok) begin
      retry_raw <= cmd_wdata_i;
      retry_steps <= wr_steps;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cmd_rdata_o <= 16'h0000;
      cml_fault_o <= 1'b0;
    end else begin
      cml_fault_o <= cml_evt;
      if (cmd_rd_i) begin
        if (cmd_code_i == frrc_pkg::CMD_RETRY) begin
          cmd_rdata_o <= retry_raw;
        end else if (wr_slot[2]) begin
          cmd_rdata_o <= {8'h00, act[wr_slot[1:0]]};
        end else begin
          cmd_rdata_o <= 16'h0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  logic uv_armed;
  logic [3:0] raw;
  logic [3:0] raw_q;
  logic [3:0] evt;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !channel_on_i || ramp_active_i) begin
      uv_armed <= 1'b0;
    end else if (turn_on_delay_done_i && turn_on_ramp_done_i &&
                 uv_threshold_reached_i && !overcurrent_limit_i) begin
      uv_armed <= 1'b1;
    end
  end

  assign raw = {startup_timeout_i, vout_uv_i && uv_armed, vout_ov_i, vin_ov_i};

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      raw_q <= 4'h0;
    end else begin
      raw_q <= raw;
    end
  end

  assign evt = raw & ~raw_q;

  // ----------------------------------------------------------------
  // Status and alert
  // ----------------------------------------------------------------
  logic [4:0] sticky;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sticky <= 5'h00;
    end else begin
      sticky <= (sticky & {5{!clear_faults_i}}) | {cml_evt, evt};
    end
  end

  always_comb begin
    status_byte_o = 8'h00;
    status_word_hi_o = 8'h00;
    status_input_o = 8'h00;
    status_vout_o = 8'h00;
    status_byte_o[frrc_pkg::SB_CML] = sticky[frrc_pkg::A_CML];
    status_byte_o[frrc_pkg::SB_NONE] = sticky[frrc_pkg::F_VIN_OV] ||
      sticky[frrc_pkg::F_VOUT_UV] || sticky[frrc_pkg::F_TON_MAX];
    status_byte_o[frrc_pkg::SB_VOUT_OV] = sticky[frrc_pkg::F_VOUT_OV];
    status_word_hi_o[frrc_pkg::SW_INPUT] = sticky[frrc_pkg::F_VIN_OV];
    status_word_hi_o[frrc_pkg::SW_VOUT] = sticky[frrc_pkg::F_VOUT_OV] ||
      sticky[frrc_pkg::F_VOUT_UV] || sticky[frrc_pkg::F_TON_MAX];
    status_input_o[frrc_pkg::SI_VIN_OV] = sticky[frrc_pkg::F_VIN_OV];
    status_vout_o[frrc_pkg::SV_OV_F] = sticky[frrc_pkg::F_VOUT_OV];
    status_vout_o[frrc_pkg::SV_OV_W] = sticky[frrc_pkg::F_VOUT_OV];
    status_vout_o[frrc_pkg::SV_UV_F] = sticky[frrc_pkg::F_VOUT_UV];
    status_vout_o[frrc_pkg::SV_UV_W] = sticky[frrc_pkg::F_VOUT_UV];
    status_vout_o[frrc_pkg::SV_TON] = sticky[frrc_pkg::F_TON_MAX];
  end

  assign alert_b_o = !(|(sticky & ~alert_mask_i));

  // ----------------------------------------------------------------
  // Response engine
  // ----------------------------------------------------------------
  frrc_pkg::frrc_state_t state;
  frrc_pkg::frrc_state_t next_state;
  logic start;
  logic [1:0] s_idx;
  logic noretry_evt;
  logic [1:0] h_src;
  logic [1:0] h_code;
  logic [2:0] h_retry;
  logic [2:0] h_delay;
  logic [23:0] elapsed;
  logic tick;
  logic delay_done;
  logic retry_done;
  logic [1:0] s_code;
  logic [2:0] s_retry;

  // Lowest slot wins when faults coincide; code 00 never starts handling
  always_comb begin
    start = 1'b0;
    s_idx = 2'h0;
    noretry_evt = 1'b0;
    for (int i = frrc_pkg::NFAULT - 1; i >= 0; i--) begin
      if (evt[i] && act[i][frrc_pkg::CODE_HI:frrc_pkg::CODE_LO] != frrc_pkg::CODE_CONT) begin
        start = channel_on_i;
        s_idx = 2'(i);
      end
      if (evt[i] && act[i][frrc_pkg::CODE_HI:frrc_pkg::CODE_LO] == frrc_pkg::CODE_SHUT &&
          act[i][frrc_pkg::RETRY_HI:frrc_pkg::RETRY_LO] != frrc_pkg::RETRY_ALWAYS) begin
        noretry_evt = 1'b1;
      end
    end
  end

  assign s_code = act[s_idx][frrc_pkg::CODE_HI:frrc_pkg::CODE_LO];
  assign s_retry = act[s_idx][frrc_pkg::RETRY_HI:frrc_pkg::RETRY_LO];

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      h_src <= 2'h0;
      h_code <= 2'h0;
      h_retry <= 3'h0;
      h_delay <= 3'h0;
    end else if (state == frrc_pkg::ST_IDLE && start) begin
      h_src <= s_idx;
      h_code <= s_code;
      h_retry <= s_retry;
      h_delay <= act[s_idx][frrc_pkg::DELAY_HI:frrc_pkg::DELAY_LO];
    end
  end

  frrc_step_tick u_tick (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .restart_i(start && state == frrc_pkg::ST_IDLE),
    .tick_o(tick)
  );

  // One counter from detection serves both the delay and the retry wait
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || (state == frrc_pkg::ST_IDLE && start)) begin
      elapsed <= 24'h000000;
    end else if (tick && state != frrc_pkg::ST_IDLE && elapsed != 24'hFFFFFF) begin
      elapsed <= elapsed + 24'h000001;
    end
  end

  assign delay_done = elapsed >= {21'h00000, h_delay};
  assign retry_done = elapsed >= retry_steps &&
    (output_discharged_i || discharge_skip_i);

  always_comb begin
    next_state = state;
    unique case (state)
      frrc_pkg::ST_IDLE: begin
        if (start && s_code == frrc_pkg::CODE_SHUT) begin
          next_state = (s_retry == frrc_pkg::RETRY_ALWAYS) ?
            frrc_pkg::ST_RETRY : frrc_pkg::ST_LATCH;
        end else if (start) begin
          next_state = frrc_pkg::ST_DELAY;
        end
      end
      frrc_pkg::ST_DELAY: begin
        if (!channel_on_i) begin
          next_state = frrc_pkg::ST_IDLE;
        end else if (noretry_evt) begin
          next_state = frrc_pkg::ST_LATCH;
        end else if (delay_done && raw[h_src]) begin
          next_state = (h_retry == frrc_pkg::RETRY_ALWAYS) ?
            frrc_pkg::ST_RETRY : frrc_pkg::ST_LATCH;
        end else if (delay_done) begin
          next_state = frrc_pkg::ST_IDLE;
        end
      end
      frrc_pkg::ST_RETRY: begin
        if (!channel_on_i) begin
          next_state = frrc_pkg::ST_IDLE;
        end else if (noretry_evt) begin
          next_state = frrc_pkg::ST_LATCH;
        end else if (retry_done) begin
          next_state = frrc_pkg::ST_IDLE;
        end
      end
      frrc_pkg::ST_LATCH: begin
        if (!channel_on_i) begin
          next_state = frrc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state <= frrc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      output_enable_o <= 1'b0;
      fault_b_o <= 1'b1;
      restart_o <= 1'b0;
      continuous_mode_o <= 1'b0;
    end else begin
      output_enable_o <= channel_on_i && (next_state == frrc_pkg::ST_IDLE ||
        next_state == frrc_pkg::ST_DELAY);
      fault_b_o <= !(channel_on_i && (next_state == frrc_pkg::ST_RETRY ||
        next_state == frrc_pkg::ST_LATCH));
      restart_o <= state == frrc_pkg::ST_RETRY && channel_on_i &&
        !noretry_evt && retry_done;
      continuous_mode_o <= channel_on_i && raw[frrc_pkg::F_VOUT_OV] &&
        act[frrc_pkg::F_VOUT_OV][frrc_pkg::CODE_HI:frrc_pkg::CODE_LO] ==
        frrc_pkg::CODE_CONT;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_shut_start;
    state == frrc_pkg::ST_IDLE && start && s_code == frrc_pkg::CODE_SHUT;
  endsequence

  sequence s_delay_running;
    state == frrc_pkg::ST_DELAY && channel_on_i && !noretry_evt && !delay_done;
  endsequence

  a_shut_disables: assert property (s_shut_start |=> !output_enable_o && !fault_b_o)
    else $error("shutdown code left output enabled");
  a_off_no_response: assert property (!channel_on_i |=> state == frrc_pkg::ST_IDLE && fault_b_o)
    else $error("response active while channel off");
  a_latch_holds: assert property (state == frrc_pkg::ST_LATCH && channel_on_i |=> state == frrc_pkg::ST_LATCH)
    else $error("latched shutdown left without off command");
  a_retry_timed: assert property (restart_o |-> $past(elapsed) >= $past(retry_steps) && $past(state) == frrc_pkg::ST_RETRY)
    else $error("restart before retry interval");
  a_discharge_gate: assert property (state == frrc_pkg::ST_RETRY && channel_on_i && !noretry_evt && !output_discharged_i && !discharge_skip_i |=> state == frrc_pkg::ST_RETRY)
    else $error("retry ended before discharge");
  a_delay_holds: assert property (s_delay_running |=> state == frrc_pkg::ST_DELAY ##0 output_enable_o)
    else $error("delay response ended early");
  a_bad_code_cml: assert property (cmd_wr_i && wr_slot[2] && cmd_wdata_i[7:6] == frrc_pkg::CODE_BAD |=> cml_fault_o && sticky[frrc_pkg::A_CML] && $stable(act[wr_slot[1:0]]))
    else $error("unsupported code accepted");
  a_vin_delay_cml: assert property (cmd_wr_i && cmd_code_i == frrc_pkg::CMD_VIN_OV && cmd_wdata_i[2:0] != 3'h0 |=> cml_fault_o)
    else $error("nonzero input delay accepted");
  a_alert_set: assert property (|(evt & ~alert_mask_i[3:0]) |=> !alert_b_o)
    else $error("unmasked fault missed alert");
  a_ov_status: assert property (evt[frrc_pkg::F_VOUT_OV] |=> status_vout_o[7:6] == 2'h3 && status_byte_o[frrc_pkg::SB_VOUT_OV])
    else $error("output overvoltage status missing");
  a_uv_masked: assert property (ramp_active_i || !channel_on_i |=> !uv_armed)
    else $error("undervoltage armed during ramp or off");

endmodule
`default_nettype wire

// *** rtl/frrc_pkg.sv ***
// Constants and types for the fault response and retry controller
package frrc_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_VOUT_OV = 8'h41;
  localparam logic [7:0] CMD_VOUT_UV = 8'h45;
  localparam logic [7:0] CMD_VIN_OV = 8'h56;
  localparam logic [7:0] CMD_TON_MAX = 8'h63;
  localparam logic [7:0] CMD_RETRY = 8'hDB;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_VOUT_OV = 8'hB8;
  localparam logic [7:0] RST_VOUT_UV = 8'h00;
  localparam logic [7:0] RST_VIN_OV = 8'hB8;
  localparam logic [7:0] RST_TON_MAX = 8'h00;
  // Linear11 10.0 ms, which is 1000 steps of 10 us
  localparam logic [15:0] RST_RETRY = 16'h000A;
  localparam logic [23:0] RST_RETRY_STEPS = 24'h0003E8;

  // ----------------------------------------------------------------
  // Fault slots, action byte fields and codes
  // ----------------------------------------------------------------
  localparam int NFAULT = 4;
  localparam logic [1:0] F_VIN_OV = 2'h0;
  localparam logic [1:0] F_VOUT_OV = 2'h1;
  localparam logic [1:0] F_VOUT_UV = 2'h2;
  localparam logic [1:0] F_TON_MAX = 2'h3;
  localparam int CODE_HI = 7;
  localparam int CODE_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] CODE_CONT = 2'h0;
  localparam logic [1:0] CODE_DELAY = 2'h1;
  localparam logic [1:0] CODE_SHUT = 2'h2;
  localparam logic [1:0] CODE_BAD = 2'h3;
  localparam logic [2:0] RETRY_ALWAYS = 3'h7;

  // ----------------------------------------------------------------
  // Interval range and step timing
  // ----------------------------------------------------------------
  localparam logic [23:0] MIN_STEPS = 24'h000002;
  localparam logic [23:0] MAX_STEPS = 24'h61A800;
  localparam logic [31:0] MS_TO_STEPS = 32'h00000064;
  localparam int STEP_NS = 10000;
  localparam int CLK_NS = 10;
  localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] STEP_LAST = 10'(STEP_CYCLES - 1);

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int SB_NONE = 0;
  localparam int SB_CML = 1;
  localparam int SB_VOUT_OV = 5;
  localparam int SW_INPUT = 5;
  localparam int SW_VOUT = 7;
  localparam int SI_VIN_OV = 7;
  localparam int SV_TON = 2;
  localparam int SV_UV_F = 4;
  localparam int SV_UV_W = 5;
  localparam int SV_OV_W = 6;
  localparam int SV_OV_F = 7;

  // Alert source order in the mask
  localparam int A_CML = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DELAY = 2'h1,
    ST_RETRY = 2'h3,
    ST_LATCH = 2'h2
  } frrc_state_t;

endpackage

// *** rtl/frrc_step_tick.sv ***
// Restartable 10 us step enable for the fault timers
`timescale 1ns/10ps
`default_nettype none
module frrc_step_tick (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic restart_i,
  output logic tick_o
);

  logic [9:0] cnt;

  // Restart aligns the step grid to the fault detection instant
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || restart_i || cnt == frrc_pkg::STEP_LAST) begin
      cnt <= 10'h000;
    end else begin
      cnt <= cnt + 10'h001;
    end
  end

  assign tick_o = (cnt == frrc_pkg::STEP_LAST) && !restart_i;

endmodule
`default_nettype wire

// *** tb/frrc_stage_model.sv ***
// Power stage and sequencer model facing the fault controller
`timescale 1ns/10ps
`default_nettype none
module frrc_stage_model (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  output logic done_o,
  output logic ramp_o,
  output logic low_o
);
  logic [3:0] age;
  logic last_en;
  // Age restarts on every enable change; decay is far shorter than any retry interval
  always_ff @(posedge clock_i) begin
    last_en <= enable_i;
    if (!rst_b_i || enable_i != last_en) begin
      age <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end
  // The cycle in which enable changes already counts as ramping
  assign done_o = enable_i && last_en && age == 4'hF;
  // Ramp covers both turn-on and turn-off, so undervoltage stays masked meanwhile
  assign ramp_o = age != 4'hF || enable_i != last_en;
  assign low_o = !enable_i && !last_en && age == 4'hF;
endmodule
`default_nettype wire

// *** tb/frrc_fault_ctrl_test.sv ***
// Self-checking bench for the fault response and retry controller
`timescale 1ns/10ps
`default_nettype none
module frrc_fault_ctrl_test;
  logic clock_i, rst_b_i, cmd_wr_i, cmd_rd_i, clear_faults_i, half_float_i, discharge_skip_i;
  logic channel_on_i, overcurrent_limit_i, vin_ov_i, vout_ov_i, vout_uv_i, startup_timeout_i;
  logic turn_on_delay_done_i, ramp_active_i, output_discharged_i;
  logic cml_fault_o, output_enable_o, continuous_mode_o, restart_o, fault_b_o, alert_b_o;
  logic [7:0] cmd_code_i, status_byte_o, status_word_hi_o, status_input_o, status_vout_o;
  logic [15:0] cmd_wdata_i, cmd_rdata_o;
  logic [4:0] alert_mask_i;
  logic [7:0] reg_cmd [5] = '{8'h41, 8'h45, 8'h56, 8'h63, 8'hDB};
  logic [15:0] reg_rst [5] = '{16'h00B8, 16'h0000, 16'h00B8, 16'h0000, 16'h000A};
  logic [7:0] bad_cmd [6] = '{8'h41, 8'h56, 8'h56, 8'h56, 8'h63, 8'hDB};
  logic [15:0] bad_dat [6] = '{16'h00C0, 16'h0000, 16'h0040, 16'h0081, 16'h00C0, 16'h0000};
  logic [15:0] bad_old [6] = '{16'h00B8, 16'h00B8, 16'h00B8, 16'h00B8, 16'h0000, 16'h000A};
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  frrc_fault_ctrl dut_u (.clock_i, .rst_b_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i, .cmd_wdata_i,
    .cmd_rdata_o, .cml_fault_o, .clear_faults_i, .alert_mask_i, .half_float_i, .discharge_skip_i,
    .channel_on_i, .turn_on_delay_done_i, .turn_on_ramp_done_i(turn_on_delay_done_i),
    .ramp_active_i, .uv_threshold_reached_i(turn_on_delay_done_i), .overcurrent_limit_i,
    .output_discharged_i, .vin_ov_i, .vout_ov_i, .vout_uv_i, .startup_timeout_i, .output_enable_o,
    .continuous_mode_o, .restart_o, .fault_b_o, .alert_b_o, .status_byte_o, .status_word_hi_o,
    .status_input_o, .status_vout_o);
  frrc_stage_model stage_u (.clock_i, .rst_b_i, .enable_i(output_enable_o),
    .done_o(turn_on_delay_done_i), .ramp_o(ramp_active_i), .low_o(output_discharged_i));
  // ----------------------------------------------------------------
  // Command and compare tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    cmd_rd_i = 1'b1;
    cmd_code_i = c;
    cyc(1);
    cmd_rd_i = 1'b0;
    chk(32'(cmd_rdata_o), 32'(e));
    cyc(1);
  endtask
  // Rejection pulse may land one or two cycles on, so both are watched
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    logic hit;
    cmd_wr_i = 1'b1;
    cmd_code_i = c;
    cmd_wdata_i = d;
    cyc(1);
    cmd_wr_i = 1'b0;
    hit = cml_fault_o;
    cyc(1);
    chk(32'(hit | cml_fault_o), 32'(e));
  endtask
  task automatic clr();
    clear_faults_i = 1'b1;
    cyc(1);
    clear_faults_i = 1'b0;
    cyc(1);
  endtask
  task automatic test_done();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {clock_i, rst_b_i, cmd_wr_i, cmd_rd_i, clear_faults_i, half_float_i, discharge_skip_i} = '0;
    {overcurrent_limit_i, vin_ov_i, vout_ov_i, vout_uv_i, startup_timeout_i} = '0;
    channel_on_i = 1'b1;
    cmd_code_i = 8'h00;
    cmd_wdata_i = 16'h0000;
    alert_mask_i = 5'h00;
    cyc(2);
    rst_b_i = 1'b1;
    foreach (reg_cmd[i]) rd(reg_cmd[i], reg_rst[i]);
    foreach (bad_cmd[i]) begin
      wr(bad_cmd[i], bad_dat[i], 1'b1);
      rd(bad_cmd[i], bad_old[i]);
    end
    chk(32'({alert_b_o, status_byte_o}), 32'h002);
    wr(8'h41, 16'h0042, 1'b0);
    wr(8'hDB, 16'hC803, 1'b0);
    rd(8'h41, 16'h0042);
    clr();
    // Interval is 2 steps of 1000 cycles, counted from detection
    vin_ov_i = 1'b1;
    cyc(4);
    chk(32'(output_enable_o), 32'h0);
    chk(32'({fault_b_o, alert_b_o, status_byte_o, status_word_hi_o, status_input_o}), 32'h12080);
    vin_ov_i = 1'b0;
    n = 4;
    while (restart_o !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 1996 && n <= 2010), 32'h1);
    chk(32'(output_enable_o), 32'h1);
    clr();
    vout_ov_i = 1'b1;
    cyc(1500);
    chk(32'(output_enable_o), 32'h1);
    cyc(3000);
    chk(32'({fault_b_o, output_enable_o, status_byte_o, status_word_hi_o, status_vout_o}), 32'h2080C0);
    vout_ov_i = 1'b0;
    channel_on_i = 1'b0;
    cyc(3);
    chk(32'(fault_b_o), 32'h1);
    channel_on_i = 1'b1;
    cyc(3);
    chk(32'(output_enable_o), 32'h1);
    channel_on_i = 1'b0;
    alert_mask_i = 5'h01;
    clr();
    vin_ov_i = 1'b1;
    cyc(3);
    chk(32'({fault_b_o, alert_b_o, status_input_o}), 32'h380);
    alert_mask_i = 5'h00;
    cyc(1);
    chk(32'(alert_b_o), 32'h0);
    vin_ov_i = 1'b0;
    clr();
    startup_timeout_i = 1'b1;
    cyc(3);
    chk(32'({status_byte_o, status_word_hi_o, status_vout_o}), 32'h018004);
    startup_timeout_i = 1'b0;
    clr();
    channel_on_i = 1'b1;
    vout_uv_i = 1'b1;
    cyc(3);
    chk(32'(status_vout_o), 32'h0);
    cyc(40);
    chk(32'({output_enable_o, status_byte_o, status_word_hi_o, status_vout_o}), 32'h1018030);
    wr(8'h41, 16'h0000, 1'b0);
    vout_ov_i = 1'b1;
    cyc(2);
    chk(32'({continuous_mode_o, output_enable_o}), 32'h3);
    vout_ov_i = 1'b0;
    cyc(2);
    chk(32'(continuous_mode_o), 32'h0);
    wr(8'hDB, 16'h4900, 1'b1);
    half_float_i = 1'b1;
    wr(8'hDB, 16'h4900, 1'b0);
    wr(8'hDB, 16'h7BFF, 1'b1);
    rd(8'hDB, 16'h4900);
    test_done();
  end
endmodule
`default_nettype wire
